// ===== pkg/mfpr_pkg.sv
package mfpr_pkg;
	localparam int unsigned NUM_PINS       = 8;
	localparam int unsigned NUM_REFS       = 8;
	localparam int unsigned NUM_CLK_OUTS   = 4;
	localparam int unsigned ADDR_W         = 12;
	localparam int unsigned DATA_W         = 8;
	localparam int unsigned CODE_W         = 7;
	localparam int unsigned DIR_BIT        = 7;
	localparam logic [11:0] PIN0_FUNC_ADDR = 12'h200;
	localparam logic [11:0] PIN7_FUNC_ADDR = 12'h207;
	localparam logic [7:0]  FUNC_RESET_VAL = 8'h00;
	localparam int unsigned SYNC_STAGES    = 2;
	localparam int unsigned WDOG_PULSE_CYC = 32;
	localparam int unsigned SYSCLK_DIV     = 32;

	// Output function codes
	localparam logic [6:0] OUT_STATIC_0    = 7'h00;
	localparam logic [6:0] OUT_STATIC_1    = 7'h01;
	localparam logic [6:0] OUT_SYSCLK_DIV  = 7'h02;
	localparam logic [6:0] OUT_WDOG        = 7'h03;
	localparam logic [6:0] OUT_REF_FAULT   = 7'h20;
	localparam logic [6:0] OUT_REF_VALID   = 7'h30;
	localparam logic [6:0] OUT_REF_ACTIVE  = 7'h40;
	localparam logic [6:0] OUT_DIST_SYNC   = 7'h50;

	// Input function codes
	localparam logic [6:0] IN_NONE         = 7'h00;
	localparam logic [6:0] IN_IO_UPDATE    = 7'h01;
	localparam logic [6:0] IN_POWER_DOWN   = 7'h02;
	localparam logic [6:0] IN_WDOG_RESET   = 7'h03;
	localparam logic [6:0] IN_IRQ_RESET    = 7'h04;
	localparam logic [6:0] IN_HIST_RESET   = 7'h05;
	localparam logic [6:0] IN_HOLDOVER     = 7'h10;
	localparam logic [6:0] IN_FREE_RUN     = 7'h11;
	localparam logic [6:0] IN_PHASE_RESET  = 7'h12;
	localparam logic [6:0] IN_PHASE_INC    = 7'h13;
	localparam logic [6:0] IN_PHASE_DEC    = 7'h14;
	localparam logic [6:0] IN_MON_OVERRIDE = 7'h20;
	localparam logic [6:0] IN_VAL_TIMEOUT  = 7'h30;
	localparam logic [6:0] IN_OUT_ENABLE   = 7'h40;
	localparam logic [6:0] IN_OUT_EN_ALL   = 7'h44;
	localparam logic [6:0] IN_DIST_SYNC    = 7'h45;
endpackage

// ===== rtl/mfpr_router.sv
// Summary of operation
// - Function byte top bit clear: pin is input, low seven bits pick a control.
// - Function byte top bit set: pin is output, low seven bits pick a status.
// - Output codes 32-39 fault, 48-55 valid, 64-71 active, order A,AA,B,BB,C,CC,D,DD.
// - Output code 80 shows the distribution sync pulse status.
// - Input codes 1-5: I/O update, power-down, watchdog, IRQ, history reset; 0 none.
// - Input codes 16-20: holdover, free run, phase offset reset, increment, decrement.
// - Input codes 32-39 monitor override, 48-55 validation timeout, per reference.
// - Input codes 64-67 enable one clock output, 68 all four, 69 sync.
// - Several pins on one control: lowest-numbered pin wins, others ignored.
// - Pin functions change only by register writes after reset, never by pins.
// - Watchdog timeout shows on an output pin as a 32-clock pulse.
`timescale 1ns/1ps
module mfpr_router
#(
	parameter int unsigned PINS = mfpr_pkg::NUM_PINS
) (
	input  wire logic                           MCLK_I,
	input  wire logic                           RSTN_I,
	input  wire logic                           CFG_WE_I,
	input  wire logic [mfpr_pkg::ADDR_W-1:0]    CFG_ADDR_I,
	input  wire logic [mfpr_pkg::DATA_W-1:0]    CFG_WDATA_I,
	output logic      [mfpr_pkg::DATA_W-1:0]    CFG_RDATA_O,
	input  wire logic [PINS-1:0]                GEN_PIN_I,
	output logic      [PINS-1:0]                GEN_PIN_O,
	output logic      [PINS-1:0]                GEN_PIN_OE_N_O,
	input  wire logic [mfpr_pkg::NUM_REFS-1:0]  REF_FAULT_I,
	input  wire logic [mfpr_pkg::NUM_REFS-1:0]  REF_VALID_I,
	input  wire logic [2:0]                     ACTIVE_REF_I,
	input  wire logic                           DIST_SYNC_PULSE_I,
	input  wire logic                           WDOG_TIMEOUT_I,
	output logic                                CTRL_IO_UPDATE_O,
	output logic                                CTRL_POWER_DOWN_O,
	output logic                                CTRL_WDOG_RESET_O,
	output logic                                CTRL_IRQ_RESET_O,
	output logic                                CTRL_HIST_RESET_O,
	output logic                                CTRL_HOLDOVER_O,
	output logic                                CTRL_FREE_RUN_O,
	output logic                                CTRL_PHASE_RESET_O,
	output logic                                CTRL_PHASE_INC_O,
	output logic                                CTRL_PHASE_DEC_O,
	output logic      [mfpr_pkg::NUM_REFS-1:0]  CTRL_MON_OVERRIDE_O,
	output logic      [mfpr_pkg::NUM_REFS-1:0]  CTRL_VAL_TIMEOUT_O,
	output logic      [mfpr_pkg::NUM_CLK_OUTS-1:0] CTRL_OUT_ENABLE_O,
	output logic                                CTRL_DIST_SYNC_O
);
	import mfpr_pkg::*;

	logic [DATA_W-1:0] func_ff [PINS];
	logic [PINS-1:0]   pin_sync;
	logic [DATA_W-1:0] rdata_ff;
	logic [4:0]        div_cnt_ff;
	logic [5:0]        wdog_cnt_ff;
	logic [PINS-1:0]   pin_out_ff;
	logic [PINS-1:0]   pin_oe_n_ff;
	logic [PINS-1:0]   nxt_pin_out;

	// Pin index arithmetic is three bits wide, so more than eight pins cannot be addressed
	if (PINS < 1 || PINS > 8)
	begin
		$error("mfpr_router: PINS must be 1 to 8");
	end

	// Two-flop synchroniser for the pad inputs
	mfpr_sync #(
		.WIDTH (PINS)
	) u_pin_sync (
		.MCLK_I  (MCLK_I),
		.RSTN_I  (RSTN_I),
		.ASYNC_I (GEN_PIN_I),
		.SYNC_O  (pin_sync)
	);

	function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
		addr_hit = (a >= PIN0_FUNC_ADDR) && (a <= PIN7_FUNC_ADDR)
			&& ((a - PIN0_FUNC_ADDR) < ADDR_W'(PINS));
	endfunction

	// Level driven by the lowest-numbered input pin that selects this code
	function automatic logic pin_ctrl(input logic [CODE_W-1:0] code,
		input logic [PINS-1:0] lvl, input logic [DATA_W-1:0] f [PINS]);
		logic hit;
		hit = 1'b0;
		pin_ctrl = 1'b0;
		for (int p = 0; p < PINS; p++)
		begin
			if (!hit && !f[p][DIR_BIT] && f[p][CODE_W-1:0] == code && code != IN_NONE)
			begin
				hit = 1'b1;
				pin_ctrl = lvl[p];
			end
		end
	endfunction

	// Configuration is touched only by the register port, so pad levels after reset never alter it
	always_ff @(posedge MCLK_I)
	begin
		if (!RSTN_I)
		begin
			for (int p = 0; p < PINS; p++)
				func_ff[p] <= FUNC_RESET_VAL;
		end
		else if (CFG_WE_I && addr_hit(CFG_ADDR_I))
		begin
			func_ff[3'(CFG_ADDR_I - PIN0_FUNC_ADDR)] <= CFG_WDATA_I;
		end
	end

	always_ff @(posedge MCLK_I)
	begin
		if (!RSTN_I)
			rdata_ff <= '0;
		else if (addr_hit(CFG_ADDR_I))
			rdata_ff <= func_ff[3'(CFG_ADDR_I - PIN0_FUNC_ADDR)];
		else
			rdata_ff <= '0;
	end

	assign CFG_RDATA_O = rdata_ff;

	// System clock divided by 32
	always_ff @(posedge MCLK_I)
	begin
		if (!RSTN_I)
			div_cnt_ff <= '0;
		else
			div_cnt_ff <= div_cnt_ff + 5'h01;
	end

	// Stretch each timeout event; a new event restarts the full width
	always_ff @(posedge MCLK_I)
	begin
		if (!RSTN_I)
			wdog_cnt_ff <= '0;
		else if (WDOG_TIMEOUT_I)
			wdog_cnt_ff <= 6'(WDOG_PULSE_CYC);
		else if (wdog_cnt_ff != 6'h00)
			wdog_cnt_ff <= wdog_cnt_ff - 6'h01;
	end

	always_comb
	begin
		logic [CODE_W-1:0] c;
		c = '0;
		for (int p = 0; p < PINS; p++)
		begin
			c = func_ff[p][CODE_W-1:0];
			nxt_pin_out[p] = 1'b0;
			if (c == OUT_STATIC_1)
				nxt_pin_out[p] = 1'b1;
			else if (c == OUT_SYSCLK_DIV)
				nxt_pin_out[p] = div_cnt_ff[4];
			else if (c == OUT_WDOG)
				nxt_pin_out[p] = (wdog_cnt_ff != 6'h00);
			else if (c >= OUT_REF_FAULT && c < OUT_REF_FAULT + 7'h08)
				nxt_pin_out[p] = REF_FAULT_I[3'(c - OUT_REF_FAULT)];
			else if (c >= OUT_REF_VALID && c < OUT_REF_VALID + 7'h08)
				nxt_pin_out[p] = REF_VALID_I[3'(c - OUT_REF_VALID)];
			else if (c >= OUT_REF_ACTIVE && c < OUT_REF_ACTIVE + 7'h08)
				nxt_pin_out[p] = (ACTIVE_REF_I == 3'(c - OUT_REF_ACTIVE));
			else if (c == OUT_DIST_SYNC)
				nxt_pin_out[p] = DIST_SYNC_PULSE_I;
			if (!func_ff[p][DIR_BIT])
				nxt_pin_out[p] = 1'b0;
		end
	end

	// Pad drivers registered so the enable and data change together
	always_ff @(posedge MCLK_I)
	begin
		if (!RSTN_I)
		begin
			pin_out_ff  <= '0;
			pin_oe_n_ff <= '1;
		end
		else
		begin
			pin_out_ff <= nxt_pin_out;
			for (int p = 0; p < PINS; p++)
				pin_oe_n_ff[p] <= ~func_ff[p][DIR_BIT];
		end
	end

	assign GEN_PIN_O      = pin_out_ff;
	assign GEN_PIN_OE_N_O = pin_oe_n_ff;

	// Control outputs from flops; adds one cycle after the synchroniser
	always_ff @(posedge MCLK_I)
	begin
		if (!RSTN_I)
		begin
			CTRL_IO_UPDATE_O    <= 1'b0;
			CTRL_POWER_DOWN_O   <= 1'b0;
			CTRL_WDOG_RESET_O   <= 1'b0;
			CTRL_IRQ_RESET_O    <= 1'b0;
			CTRL_HIST_RESET_O   <= 1'b0;
			CTRL_HOLDOVER_O     <= 1'b0;
			CTRL_FREE_RUN_O     <= 1'b0;
			CTRL_PHASE_RESET_O  <= 1'b0;
			CTRL_PHASE_INC_O    <= 1'b0;
			CTRL_PHASE_DEC_O    <= 1'b0;
			CTRL_MON_OVERRIDE_O <= '0;
			CTRL_VAL_TIMEOUT_O  <= '0;
			CTRL_OUT_ENABLE_O   <= '0;
			CTRL_DIST_SYNC_O    <= 1'b0;
		end
		else
		begin
			CTRL_IO_UPDATE_O   <= pin_ctrl(IN_IO_UPDATE, pin_sync, func_ff);
			CTRL_POWER_DOWN_O  <= pin_ctrl(IN_POWER_DOWN, pin_sync, func_ff);
			CTRL_WDOG_RESET_O  <= pin_ctrl(IN_WDOG_RESET, pin_sync, func_ff);
			CTRL_IRQ_RESET_O   <= pin_ctrl(IN_IRQ_RESET, pin_sync, func_ff);
			CTRL_HIST_RESET_O  <= pin_ctrl(IN_HIST_RESET, pin_sync, func_ff);
			CTRL_HOLDOVER_O    <= pin_ctrl(IN_HOLDOVER, pin_sync, func_ff);
			CTRL_FREE_RUN_O    <= pin_ctrl(IN_FREE_RUN, pin_sync, func_ff);
			CTRL_PHASE_RESET_O <= pin_ctrl(IN_PHASE_RESET, pin_sync, func_ff);
			CTRL_PHASE_INC_O   <= pin_ctrl(IN_PHASE_INC, pin_sync, func_ff);
			CTRL_PHASE_DEC_O   <= pin_ctrl(IN_PHASE_DEC, pin_sync, func_ff);
			for (int r = 0; r < NUM_REFS; r++)
			begin
				CTRL_MON_OVERRIDE_O[r] <= pin_ctrl(IN_MON_OVERRIDE + 7'(r), pin_sync, func_ff);
				CTRL_VAL_TIMEOUT_O[r]  <= pin_ctrl(IN_VAL_TIMEOUT + 7'(r), pin_sync, func_ff);
			end
			// The all-outputs code is its own control, so it ORs with the single enables
			for (int k = 0; k < NUM_CLK_OUTS; k++)
				CTRL_OUT_ENABLE_O[k] <= pin_ctrl(IN_OUT_ENABLE + 7'(k), pin_sync, func_ff)
					| pin_ctrl(IN_OUT_EN_ALL, pin_sync, func_ff);
			CTRL_DIST_SYNC_O <= pin_ctrl(IN_DIST_SYNC, pin_sync, func_ff);
		end
	end
endmodule

// ===== rtl/mfpr_sync.sv
`timescale 1ns/1ps
module mfpr_sync #(
	parameter int unsigned WIDTH = 8
) (
	input  wire logic             MCLK_I,
	input  wire logic             RSTN_I,
	input  wire logic [WIDTH-1:0] ASYNC_I,
	output logic      [WIDTH-1:0] SYNC_O
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	if (WIDTH < 1)
	begin
		$error("mfpr_sync: WIDTH must be at least 1");
	end

	// First stage feeds only the second stage
	always_ff @(posedge MCLK_I)
	begin
		if (!RSTN_I)
		begin
			meta_ff <= '0;
			sync_ff <= '0;
		end
		else
		begin
			meta_ff <= ASYNC_I;
			sync_ff <= meta_ff;
		end
	end

	assign SYNC_O = sync_ff;
endmodule

// ===== tb/mfpr_board.sv
`timescale 1ns/1ps
module mfpr_board (
	input  wire logic       MCLK_I,
	input  wire logic [7:0] want_i,
	input  wire logic [7:0] dev_pin_i,
	input  wire logic [7:0] dev_oe_n_i,
	output logic      [7:0] pad_o
);
	logic [7:0] lvl_ff;
	// Board levels move just after a posedge of MCLK_I, the same edge the device samples on
	always_ff @(posedge MCLK_I)
		lvl_ff <= want_i;
	// The pad follows the device wherever it drives, the board elsewhere
	assign pad_o = (dev_pin_i & ~dev_oe_n_i) | (lvl_ff & dev_oe_n_i);
endmodule

// ===== tb/mfpr_router_asserts.sv
`timescale 1ns/1ps
module mfpr_router_asserts (
	input wire logic        MCLK_I,
	input wire logic        RSTN_I,
	input wire logic        CFG_WE_I,
	input wire logic [11:0] CFG_ADDR_I,
	input wire logic [7:0]  CFG_WDATA_I,
	input wire logic [7:0]  CFG_RDATA_O,
	input wire logic [7:0]  GEN_PIN_I,
	input wire logic [7:0]  GEN_PIN_O,
	input wire logic [7:0]  GEN_PIN_OE_N_O,
	input wire logic [7:0]  REF_FAULT_I,
	input wire logic        WDOG_TIMEOUT_I,
	input wire logic        CTRL_PHASE_INC_O
);
	logic [7:0] pin0_ff;
	// Shadow of pin 0's function byte, so rules can be judged per mode
	always_ff @(posedge MCLK_I)
		if (!RSTN_I)
			pin0_ff <= 8'h00;
		else if (CFG_WE_I && CFG_ADDR_I == 12'h200)
			pin0_ff <= CFG_WDATA_I;
	default clocking dc @(posedge MCLK_I); endclocking
	default disable iff (!RSTN_I);
	a_out_dir_drive: assert property (CFG_WE_I && CFG_ADDR_I == 12'h200 && CFG_WDATA_I[7]
		##1 !(CFG_WE_I && CFG_ADDR_I == 12'h200) |=> !GEN_PIN_OE_N_O[0]) else $error("output pin not driven");
	a_in_dir_float: assert property (CFG_WE_I && CFG_ADDR_I == 12'h200 && !CFG_WDATA_I[7]
		##1 !(CFG_WE_I && CFG_ADDR_I == 12'h200) |=> GEN_PIN_OE_N_O[0]) else $error("input pin driven");
	a_input_low: assert property ((GEN_PIN_O & GEN_PIN_OE_N_O) == 8'h00)
		else $error("undriven pin data not low");
	a_unmapped_zero: assert property (!(CFG_ADDR_I inside {[12'h200:12'h207]}) |=> CFG_RDATA_O == 8'h00)
		else $error("unmapped read not zero");
	a_read_back: assert property (CFG_WE_I && CFG_ADDR_I == 12'h203 ##1 CFG_ADDR_I == 12'h203 && !CFG_WE_I
		|=> CFG_RDATA_O == $past(CFG_WDATA_I, 2)) else $error("read back differs");
	a_fault_follow: assert property ($past(pin0_ff) == 8'hA0 |-> GEN_PIN_O[0] == $past(REF_FAULT_I[0]))
		else $error("fault flag not shown");
	a_wdog_stretch: assert property (pin0_ff == 8'h83 && WDOG_TIMEOUT_I ##1 pin0_ff == 8'h83
		|=> ##1 GEN_PIN_O[0] [*8] ##23 GEN_PIN_O[0]) else $error("watchdog pulse too short");
	a_phase_follow: assert property (pin0_ff == 8'h13 && $past(pin0_ff, 4) == 8'h13
		|-> CTRL_PHASE_INC_O == $past(GEN_PIN_I[0], 3)) else $error("phase step control wrong");
endmodule
bind mfpr_router mfpr_router_asserts u_chk (
	.MCLK_I           (MCLK_I),
	.RSTN_I           (RSTN_I),
	.CFG_WE_I         (CFG_WE_I),
	.CFG_ADDR_I       (CFG_ADDR_I),
	.CFG_WDATA_I      (CFG_WDATA_I),
	.CFG_RDATA_O      (CFG_RDATA_O),
	.GEN_PIN_I        (GEN_PIN_I),
	.GEN_PIN_O        (GEN_PIN_O),
	.GEN_PIN_OE_N_O   (GEN_PIN_OE_N_O),
	.REF_FAULT_I      (REF_FAULT_I),
	.WDOG_TIMEOUT_I   (WDOG_TIMEOUT_I),
	.CTRL_PHASE_INC_O (CTRL_PHASE_INC_O)
);

// ===== tb/multifunction_pin_router_test.sv
`timescale 1ns/1ps
module multifunction_pin_router_test;
	logic        clk, rst_n, we, dsync, wd;
	logic [11:0] addr;
	logic [7:0]  wdata, want, flt, vld, rdata, pin_o, oe_n, pad;
	logic [2:0]  act;
	wire  [30:0] ctl;
	int          err_total = 0, total_checks = 0, cyc = 0;
	mfpr_router dut (.MCLK_I(clk), .RSTN_I(rst_n), .CFG_WE_I(we), .CFG_ADDR_I(addr), .CFG_WDATA_I(wdata),
		.CFG_RDATA_O(rdata), .GEN_PIN_I(pad), .GEN_PIN_O(pin_o), .GEN_PIN_OE_N_O(oe_n), .REF_FAULT_I(flt),
		.REF_VALID_I(vld), .ACTIVE_REF_I(act), .DIST_SYNC_PULSE_I(dsync), .WDOG_TIMEOUT_I(wd),
		.CTRL_IO_UPDATE_O(ctl[0]), .CTRL_POWER_DOWN_O(ctl[1]), .CTRL_WDOG_RESET_O(ctl[2]),
		.CTRL_IRQ_RESET_O(ctl[3]), .CTRL_HIST_RESET_O(ctl[4]), .CTRL_HOLDOVER_O(ctl[5]),
		.CTRL_FREE_RUN_O(ctl[6]), .CTRL_PHASE_RESET_O(ctl[7]), .CTRL_PHASE_INC_O(ctl[8]),
		.CTRL_PHASE_DEC_O(ctl[9]), .CTRL_MON_OVERRIDE_O(ctl[17:10]), .CTRL_VAL_TIMEOUT_O(ctl[25:18]),
		.CTRL_OUT_ENABLE_O(ctl[29:26]), .CTRL_DIST_SYNC_O(ctl[30]));
	mfpr_board u_brd (.MCLK_I(clk), .want_i(want), .dev_pin_i(pin_o), .dev_oe_n_i(oe_n), .pad_o(pad));
	task automatic tally_and_finish;
		if (err_total == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		we <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		we <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		repeat (2) @(posedge clk);
		#1 chk(rdata, e);
	endtask
	// Waits on the pad path: board flop, two sync stages, output flop, plus margin
	task automatic pads(input logic [7:0] v);
		@(posedge clk);
		want <= v;
		repeat (8) @(posedge clk);
		#1;
	endtask
	task automatic t_reset;
		for (int i = 0; i < 8; i++)
			rd(12'h200 + 12'(i), 8'h00);
		rd(12'h208, 8'h00);
		chk({pin_o, oe_n}, 16'h00FF);
		chk(ctl, 32'h0);
		wr(12'h203, 8'hA5);
		rd(12'h203, 8'hA5);
	endtask
	task automatic opin(input logic [6:0] c, input logic e);
		wr(12'h200, {1'b1, c});
		repeat (3) @(posedge clk);
		#1 chk({oe_n[0], pin_o[0]}, {1'b0, e});
	endtask
	task automatic t_out;
		for (int k = 0; k < 8; k++)
		begin
			@(posedge clk);
			flt <= 8'h01 << k;
			vld <= ~(8'h01 << k);
			act <= 3'(k);
			opin(7'h20 + 7'(k), 1'b1);
			opin(7'h30 + 7'(k), 1'b0);
			opin(7'h40 + 7'(k), 1'b1);
		end
		@(posedge clk);
		dsync <= 1'b1;
		opin(7'h50, 1'b1);
		opin(7'h28, 1'b0);
		opin(7'h01, 1'b1);
		opin(7'h00, 1'b0);
	endtask
	task automatic t_wdog;
		int n = 0;
		wr(12'h200, 8'h83);
		@(posedge clk);
		wd <= 1'b1;
		@(posedge clk);
		wd <= 1'b0;
		repeat (40)
		begin
			@(posedge clk);
			#1 n += int'(pin_o[0] === 1'b1);
		end
		chk(n, 32);
	endtask
	task automatic t_in;
		logic [30:0] e;
		for (int c = 0; c < 71; c++)
		begin
			case (7'(c)) inside
				[7'h01:7'h05]: e = 31'h1 << (c - 1);
				[7'h10:7'h14]: e = 31'h1 << (c - 11);
				[7'h20:7'h27]: e = 31'h1 << (c - 22);
				[7'h30:7'h37]: e = 31'h1 << (c - 30);
				[7'h40:7'h43]: e = 31'h1 << (c - 38);
				7'h44: e = 31'hF << 26;
				7'h45: e = 31'h1 << 30;
				default: e = 31'h0;
			endcase
			wr(12'h200, 8'(c));
			pads(8'h01);
			chk({oe_n[0], ctl}, {1'b1, e});
			pads(8'h00);
			chk(ctl, 32'h0);
		end
	endtask
	task automatic t_prio;
		wr(12'h200, 8'h00);
		wr(12'h201, 8'h13);
		wr(12'h203, 8'h13);
		pads(8'h08);
		chk(ctl[8], 1'b0);
		pads(8'h02);
		chk(ctl[8], 1'b1);
		wr(12'h201, 8'h93);
		pads(8'h08);
		chk(ctl[8], 1'b1);
	endtask
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Whole run is under two thousand cycles; the ceiling leaves wide margin
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			tally_and_finish;
		end
	end
	initial
	begin
		{rst_n, we, dsync, wd, addr, wdata, want, flt, vld, act} = '0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_reset;
		t_out;
		t_wdog;
		t_in;
		t_prio;
		tally_and_finish;
	end
endmodule
